// ### common/acs_pkg.sv
// package of constants and types for the conversion start control block
package acs_pkg;
   // output code layout
   localparam int          CODE_W        = 24;
   localparam logic [23:0] CODE_POS_FULL = 24'h7fffff;
   localparam logic [23:0] CODE_NEG_FULL = 24'h800000;
   // rate select codes that give high-speed mode
   localparam logic [2:0]  RATE_HS_LO    = 3'h4;
   localparam logic [2:0]  RATE_HS_HI    = 3'h5;
   // clock rate
   localparam int          MCLK_HZ       = 20000000;
   // settling times in nanoseconds, per filter path
   localparam int          SETTLE_LL_NS  = 3625;
   localparam int          SETTLE_WB_NS  = 20000;
   // least time rounds up to whole cycles
   localparam int          SETTLE_LL_CYC = (SETTLE_LL_NS * (MCLK_HZ / 1000000) + 999) / 1000;
   localparam int          SETTLE_WB_CYC = (SETTLE_WB_NS * (MCLK_HZ / 1000000) + 999) / 1000;
   // period between results in continuous mode, nanoseconds
   localparam int          PERIOD_HS_NS  = 1000;
   localparam int          PERIOD_LS_NS  = 2000;
   localparam int          PERIOD_HS_CYC = (PERIOD_HS_NS * (MCLK_HZ / 1000000) + 999) / 1000;
   localparam int          PERIOD_LS_CYC = (PERIOD_LS_NS * (MCLK_HZ / 1000000) + 999) / 1000;
   localparam int          CNT_W         = 16;
   // conversion states
   typedef enum logic [1:0] {
      ACS_IDLE   = 2'b00,
      ACS_SETTLE = 2'b01,
      ACS_RUN    = 2'b10
   } acs_state_t;
endpackage

// ### logic/acs_code_map.sv
// saturating mapping of a signed difference onto a 24-bit output code
`timescale 1ns/1ns
module acs_code_map
   import acs_pkg::*;
(
   // analog samples as signed words
   input  wire logic signed [CODE_W:0]   diff_in,
   input  wire logic signed [CODE_W:0]   ref_in,
   // mapped output code
   output logic         [CODE_W-1:0]     code
);
   // wide product keeps precision before the divide
   logic signed [2*CODE_W+1:0] scaled;
   always_comb begin
      scaled = '0;
      code   = '0;
      if (diff_in >= ref_in) begin
         code = CODE_POS_FULL;
      end else if (diff_in <= -ref_in) begin
         code = CODE_NEG_FULL;
      end else begin
         // linear scale, inside limits so no wrap
         scaled = (diff_in * $signed({1'b0, CODE_POS_FULL})) / ref_in;
         code   = scaled[CODE_W-1:0];
      end
   end
endmodule

// ### logic/acs_conv_ctrl.sv
// conversion start control with settle timing and result coding
`timescale 1ns/1ns
// Notes on behaviour
// - input at or above reference gives 7fffff
// - input at or below negative reference gives 800000
// - start sampled only on mclk rising edge
// - held start keeps converting successive results
// - new start pulse restarts a running conversion
// - aborted partial result is never presented
// - ready flag only after filter settles
// - rate codes 100 and 101 select high speed
module acs_conv_ctrl
   import acs_pkg::*;
(
   // clock and reset
   input  wire logic                     mclk,
   input  wire logic                     rstn,
   // host control pins
   input  wire logic                     start,
   input  wire logic [2:0]               rate_select,
   input  wire logic                     filter_path_select,
   // analog inputs as signed samples
   input  wire logic signed [CODE_W:0]   input_pos,
   input  wire logic signed [CODE_W:0]   input_neg,
   input  wire logic signed [CODE_W:0]   ref_pos,
   input  wire logic signed [CODE_W:0]   ref_neg,
   // results
   output logic                          result_valid_flag,
   output logic         [CODE_W-1:0]     result_data,
   output logic                          high_speed,
   output logic                          busy
);
   ////////////////////////////////////////////////////////////////////////////
   // state record
   typedef struct packed {
      acs_state_t          st;        // conversion state
      logic                start_q;   // start as last sampled
      logic [CNT_W-1:0]    cnt;       // cycles left in phase
      logic                flag;      // ready pulse
      logic [CODE_W-1:0]   data;      // presented result
      logic                hs;        // speed mode
      logic                busy;      // conversion running
   } acs_reg_t;

   acs_reg_t r;        // registered state
   acs_reg_t next_r;   // next state

   logic [CODE_W-1:0] code_now;  // live coded sample
   logic              start_rise; // fresh start pulse

   ////////////////////////////////////////////////////////////////////////////
   // full-scale coding of the current differential sample
   // the map is combinational; only the sample present at the edge where the
   // count is already zero is captured, one edge after it reaches zero, so earlier samples of an aborted run never reach the port
   acs_code_map u_map (
      .diff_in (input_pos - input_neg),
      .ref_in  (ref_pos - ref_neg),
      .code    (code_now)
   );

   // speed mode decode
   function automatic logic is_hs(input logic [2:0] rs);
      return (rs == RATE_HS_LO) || (rs == RATE_HS_HI);
   endfunction

   // settle length for the selected path
   function automatic logic [CNT_W-1:0] settle_len(input logic ll);
      return ll ? CNT_W'(SETTLE_LL_CYC - 1) : CNT_W'(SETTLE_WB_CYC - 1);
   endfunction

   assign start_rise = start && !r.start_q;

   ////////////////////////////////////////////////////////////////////////////
   // next-state logic
   always_comb begin
      next_r         = r;
      next_r.start_q = start;
      next_r.flag    = 1'b0;
      next_r.hs      = is_hs(rate_select);
      case (r.st)
         ACS_IDLE: begin
            if (start_rise) begin
               next_r.st   = ACS_SETTLE;
               next_r.cnt  = settle_len(filter_path_select);
               next_r.busy = 1'b1;
            end
         end
         ACS_SETTLE, ACS_RUN: begin
            if (start_rise) begin
               // restart: drop partial work, rearm the settle count
               next_r.st  = ACS_SETTLE;
               next_r.cnt = settle_len(filter_path_select);
            end else if (r.cnt != '0) begin
               next_r.cnt = r.cnt - CNT_W'(1);
            end else begin
               // settled: publish the result
               next_r.flag = 1'b1;
               next_r.data = code_now;
               if (start) begin
                  // held high: keep producing results
                  next_r.st  = ACS_RUN;
                  next_r.cnt = r.hs ? CNT_W'(PERIOD_HS_CYC - 1)
                                    : CNT_W'(PERIOD_LS_CYC - 1);
               end else begin
                  next_r.st   = ACS_IDLE;
                  next_r.busy = 1'b0;
               end
            end
         end
         default: begin
            next_r.st   = ACS_IDLE;
            next_r.busy = 1'b0;
         end
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   // state register
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         r <= '0;
      end else begin
         r <= next_r;
      end
   end

   // outputs straight from flip-flops
   assign result_valid_flag = r.flag;
   assign result_data       = r.data;
   assign high_speed        = r.hs;
   assign busy              = r.busy;

   ////////////////////////////////////////////////////////////////////////////
   // checks
   sequence s_restart;
      start && !$past(start) && busy;
   endsequence

   // a start edge as the control logic sees it
   sequence s_take;
      start && !r.start_q;
   endsequence

   property p_hs_decode;
      @(posedge mclk) disable iff (!rstn)
      1'b1 |=> high_speed == $past(rate_select == RATE_HS_LO || rate_select == RATE_HS_HI);
   endproperty
   a_hs_decode: assert property (p_hs_decode) else $error("speed mode decode wrong");

   property p_restart_no_flag;
      @(posedge mclk) disable iff (!rstn)
      s_restart |=> !result_valid_flag [*2];
   endproperty
   a_restart_no_flag: assert property (p_restart_no_flag) else $error("flag after restart");

   property p_restart_busy;
      @(posedge mclk) disable iff (!rstn)
      (start && !r.start_q) |=> busy && r.st == ACS_SETTLE;
   endproperty
   a_restart_busy: assert property (p_restart_busy) else $error("start not taken");

   property p_flag_pulse;
      @(posedge mclk) disable iff (!rstn)
      result_valid_flag |=> !result_valid_flag;
   endproperty
   a_flag_pulse: assert property (p_flag_pulse) else $error("flag wider than a cycle");

   property p_settle_time;
      @(posedge mclk) disable iff (!rstn)
      (start && !r.start_q && filter_path_select) |=> !result_valid_flag [*8];
   endproperty
   a_settle_time: assert property (p_settle_time) else $error("flag before settle");

   property p_continuous;
      @(posedge mclk) disable iff (!rstn)
      (result_valid_flag && start && $past(start)) |-> busy;
   endproperty
   a_continuous: assert property (p_continuous) else $error("held start stopped");

   property p_idle_flag;
      @(posedge mclk) disable iff (!rstn)
      !busy && !$past(busy) |-> !result_valid_flag;
   endproperty
   a_idle_flag: assert property (p_idle_flag) else $error("flag while idle");

   property p_ll_settle;
      @(posedge mclk) disable iff (!rstn)
      s_take ##0 filter_path_select |=> r.st == ACS_SETTLE && r.cnt == CNT_W'(SETTLE_LL_CYC - 1);
   endproperty
   a_ll_settle: assert property (p_ll_settle) else $error("short path settle count");

   property p_wb_settle;
      @(posedge mclk) disable iff (!rstn)
      s_take ##0 !filter_path_select |=> r.st == ACS_SETTLE && r.cnt == CNT_W'(SETTLE_WB_CYC - 1);
   endproperty
   a_wb_settle: assert property (p_wb_settle) else $error("wide path settle count");

   property p_data_hold;
      @(posedge mclk) disable iff (!rstn)
      !result_valid_flag |-> $stable(result_data);
   endproperty
   a_data_hold: assert property (p_data_hold) else $error("data moved without flag");

   property p_busy_release;
      @(posedge mclk) disable iff (!rstn)
      result_valid_flag && !$past(start) |-> !busy;
   endproperty
   a_busy_release: assert property (p_busy_release) else $error("busy after single run");

   property p_pos_full;
      @(posedge mclk) disable iff (!rstn)
      (r.st != ACS_IDLE && !start_rise && r.cnt == '0 && input_pos - input_neg >= ref_pos - ref_neg)
         |=> result_data == CODE_POS_FULL;
   endproperty
   a_pos_full: assert property (p_pos_full) else $error("positive clamp wrong");

   property p_neg_full;
      @(posedge mclk) disable iff (!rstn)
      (r.st != ACS_IDLE && !start_rise && r.cnt == '0 && input_pos - input_neg <= ref_neg - ref_pos)
         |=> result_data == CODE_NEG_FULL;
   endproperty
   a_neg_full: assert property (p_neg_full) else $error("negative clamp wrong");
endmodule

// ### bench/acs_host_model.sv
// host model that drives the start pin
`timescale 1ns/1ns
module acs_host_model (
   // clock
   input  wire logic mclk,
   // start pin to the converter
   output logic      start
);
   initial start = 1'b0;
   // strobe start for n cycles, used by each strobed conversion
   task automatic pulse(input int n);
      @(posedge mclk);
      start <= 1'b1;
      repeat (n) @(posedge mclk);
      start <= 1'b0;
   endtask
   // hold start at a level for continuous runs
   task automatic hold(input logic v);
      @(posedge mclk);
      start <= v;
   endtask
endmodule

// ### bench/adc_conversion_start_control_tb.sv
// self-checking bench for the conversion start control block
`timescale 1ns/1ns
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin n_fail++; \
   $display("[ERR] %0t got %0h exp %0h", $time, a, b); end end
module adc_conversion_start_control_tb import acs_pkg::*;;
   logic                   mclk, rstn, start, fps, vld, hs, busy;
   logic [2:0]             rate;
   logic signed [CODE_W:0] ip, in, rp, rn;
   logic [CODE_W-1:0]      data;
   int                     n_fail = 0;
   int                     n_compared = 0;
   int                     c;
   // device and host
   acs_conv_ctrl uut (.mclk(mclk), .rstn(rstn), .start(start), .rate_select(rate),
      .filter_path_select(fps), .input_pos(ip), .input_neg(in), .ref_pos(rp),
      .ref_neg(rn), .result_valid_flag(vld), .result_data(data), .high_speed(hs),
      .busy(busy));
   acs_host_model host (.mclk(mclk), .start(start));
   initial begin
      mclk = 1'b0;
      forever #25 mclk = ~mclk;
   end
   // verdict and end of run
   task automatic final_report();
      $display("compared %0d failed %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   // bounded wait for the next ready pulse
   task automatic wflag();
      c = 0;
      do begin
         @(posedge mclk);
         c++;
         if (c > 2000) begin n_fail++; final_report(); end
      end while (vld !== 1'b1);
   endtask
   // one strobed conversion, ready near the settle count
   task automatic conv(input int s);
      host.pulse(2);
      wflag();
      `CHK(c, s)
   endtask
   // code table over both limits and mid-scale
   task automatic t_codes();
      logic signed [CODE_W:0] v [4] = '{2000, 1000, 0, -1000};
      // reference span is 2000: mid values are half scale, rounded toward zero
      logic [CODE_W-1:0]      e [4] = '{CODE_POS_FULL, 24'h3fffff, 24'h0, 24'hc00001};
      for (int i = 0; i < 4; i++) begin
         @(posedge mclk);
         ip <= v[i];
         conv(SETTLE_LL_CYC);
         `CHK(data, e[i])
      end
      @(posedge mclk);
      fps <= 1'b0;
      ip  <= -3000;
      conv(SETTLE_WB_CYC);
      `CHK(data, CODE_NEG_FULL)
   endtask
   // restart mid-conversion, old result never shows
   task automatic t_restart();
      @(posedge mclk);
      fps <= 1'b1;
      ip  <= 2000;
      host.pulse(2);
      repeat (20) @(posedge mclk);
      ip <= -2000;
      conv(SETTLE_LL_CYC);
      `CHK(data, CODE_NEG_FULL)
   endtask
   // every rate code against the speed decode
   task automatic t_rate();
      for (int r = 0; r < 8; r++) begin
         @(posedge mclk);
         rate <= r[2:0];
         repeat (2) @(posedge mclk);
         `CHK(hs, (r[2:0] == RATE_HS_LO || r[2:0] == RATE_HS_HI))
      end
   endtask
   // held start gives results at the high-speed period
   task automatic t_cont();
      @(posedge mclk);
      rate <= RATE_HS_HI;
      host.hold(1'b1);
      wflag();
      wflag();
      `CHK(c, PERIOD_HS_CYC)
      host.hold(1'b0);
      wflag();
      repeat (2) @(posedge mclk);
      `CHK(busy, 1'b0)
   endtask
   // main sequence
   initial begin
      rstn = 1'b0;
      fps  = 1'b1;
      rate = 3'h0;
      ip   = 0;
      in   = 0;
      rp   = 1000;
      rn   = -1000;
      repeat (20) @(posedge mclk);
      `CHK({vld, hs, busy, data}, 27'h0)
      rstn <= 1'b1;
      t_codes();
      t_restart();
      t_rate();
      t_cont();
      final_report();
   end
endmodule
